// [verilog/dcpwm_top.sv]
// Dual-channel pulse-width modulator with three special function registers
//
// Summary of operation
// - Control bits 7:6 pick 31/63/127/255 period
// - Core clock divided by prescale field plus one
// - Control bit 1 enables second channel pin
// - Control bit 0 enables first channel pin
// - Shared period and prescale, separate duty registers
// - Duty uses low resolution bits over period
// - Duty write takes effect immediately
// - Registers at 0xB2, 0xA1, 0xA2, read/write
`timescale 1ns/10ps
`default_nettype none
module dcpwm_top
	import dcpwm_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic           reset_n,
	input  wire logic           clk_en,
	input  wire dcpwm_sfr_req_t sfr_req,
	output logic [7:0]          sfr_rdata_q,
	output logic                sfr_hit_q,
	output logic                pulse_out_a,
	output logic                pulse_out_b
);

	// --------------------------------------------------------------------------
	// Register file
	// --------------------------------------------------------------------------
	logic [7:0] period_ctrl_reg_q;
	logic [7:0] duty_reg_a_q;
	logic [7:0] duty_reg_b_q;
	logic       sel_ctrl;
	logic       sel_a;
	logic       sel_b;
	logic       wr_ctrl;
	logic       wr_duty_a;
	logic       wr_duty_b;
	logic       rd_mapped;

	// Address decode of the three special function registers
	always_comb begin
		sel_ctrl = 1'b0;
		sel_a    = 1'b0;
		sel_b    = 1'b0;
		if (sfr_req.addr == DCPWM_ADDR_PERIOD_CTRL) begin
			sel_ctrl = 1'b1;
		end else if (sfr_req.addr == DCPWM_ADDR_DUTY_A) begin
			sel_a = 1'b1;
		end else if (sfr_req.addr == DCPWM_ADDR_DUTY_B) begin
			sel_b = 1'b1;
		end
	end

	// Write strobes carry the clock enable, so a frozen core can never
	// slip a write into a register while the rest of the block stands still
	assign wr_ctrl   = clk_en && sfr_req.wr && sel_ctrl;
	assign wr_duty_a = clk_en && sfr_req.wr && sel_a;
	assign wr_duty_b = clk_en && sfr_req.wr && sel_b;

	// Only the three mapped addresses answer a read
	assign rd_mapped = sfr_req.rd && (sel_ctrl || sel_a || sel_b);

	// Control register writes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			period_ctrl_reg_q <= DCPWM_RESET_CTRL;
		end else if (wr_ctrl) begin
			period_ctrl_reg_q <= sfr_req.wdata;
		end
	end

	// Duty register writes; no shadowing, so the new value acts at once
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			duty_reg_a_q <= DCPWM_RESET_DUTY;
			duty_reg_b_q <= DCPWM_RESET_DUTY;
		end else begin
			if (wr_duty_a) begin
				duty_reg_a_q <= sfr_req.wdata;
			end
			if (wr_duty_b) begin
				duty_reg_b_q <= sfr_req.wdata;
			end
		end
	end

	// Read data; unmapped addresses read zero and leave the hit flag low
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sfr_rdata_q <= 8'h00;
			sfr_hit_q   <= 1'b0;
		end else if (clk_en) begin
			sfr_hit_q <= rd_mapped;
			if (!sfr_req.rd) begin
				sfr_rdata_q <= 8'h00;
			end else if (sel_ctrl) begin
				sfr_rdata_q <= period_ctrl_reg_q;
			end else if (sel_a) begin
				sfr_rdata_q <= duty_reg_a_q;
			end else if (sel_b) begin
				sfr_rdata_q <= duty_reg_b_q;
			end else begin
				sfr_rdata_q <= 8'h00;
			end
		end
	end

	// --------------------------------------------------------------------------
	// Shared timebase
	// --------------------------------------------------------------------------
	logic [3:0]      prescale;
	logic [1:0]      res_sel;
	logic [7:0]      period_top;
	logic [3:0]      pre_cnt_q;
	logic [7:0]      per_cnt_q;
	logic            tick;
	dcpwm_timebase_t timebase;

	assign prescale = period_ctrl_reg_q[DCPWM_PRESCALE_MSB:DCPWM_PRESCALE_LSB];
	assign res_sel  = period_ctrl_reg_q[DCPWM_RES_MSB:DCPWM_RES_LSB];

	// Period length for the selected resolution; also the duty bit mask
	always_comb begin
		case (res_sel)
			2'h0:    period_top = DCPWM_PERIOD_5B;
			2'h1:    period_top = DCPWM_PERIOD_6B;
			2'h2:    period_top = DCPWM_PERIOD_7B;
			default: period_top = DCPWM_PERIOD_8B;
		endcase
	end

	// Prescaler: one tick every prescale+1 core clocks
	assign tick = (pre_cnt_q >= prescale);
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pre_cnt_q <= 4'h0;
		end else if (clk_en) begin
			pre_cnt_q <= tick ? 4'h0 : pre_cnt_q + 4'h1;
		end
	end

	// Period counter runs 0..top-1, so a period is top counts long.
	// A resolution change that leaves the count above top wraps at once.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			per_cnt_q <= 8'h00;
		end else if (clk_en && tick) begin
			per_cnt_q <= (per_cnt_q >= period_top - 8'h01) ? 8'h00 : per_cnt_q + 8'h01;
		end
	end

	assign timebase.tick  = tick;
	assign timebase.count = per_cnt_q;
	assign timebase.mask  = period_top;

	// --------------------------------------------------------------------------
	// Output channels
	// --------------------------------------------------------------------------
	logic [1:0] ch_en;
	logic [1:0] ch_pulse;
	logic [7:0] ch_duty [2];

	assign ch_en[0]   = period_ctrl_reg_q[DCPWM_EN_A_BIT];
	assign ch_en[1]   = period_ctrl_reg_q[DCPWM_EN_B_BIT];
	assign ch_duty[0] = duty_reg_a_q;
	assign ch_duty[1] = duty_reg_b_q;

	// One compare channel per output, sharing the timebase
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		dcpwm_channel u_channel (
			.sys_clk  (sys_clk),
			.reset_n  (reset_n),
			.clk_en   (clk_en),
			.timebase (timebase),
			.duty     (ch_duty[ch]),
			.enable   (ch_en[ch]),
			.pulse_q  (ch_pulse[ch])
		);
	end

	// Channel flip-flops drive the pins directly; disabled channels sit low
	assign pulse_out_a = ch_pulse[0];
	assign pulse_out_b = ch_pulse[1];

endmodule
`default_nettype wire

// [common/dcpwm_pkg.sv]
// Package for the dual-channel pulse-width modulator: addresses, fields, carriers
package dcpwm_pkg;

	// --------------------------------------------------------------------------
	// Special function register addresses
	// --------------------------------------------------------------------------
	localparam logic [7:0] DCPWM_ADDR_PERIOD_CTRL = 8'hB2;
	localparam logic [7:0] DCPWM_ADDR_DUTY_A      = 8'hA1;
	localparam logic [7:0] DCPWM_ADDR_DUTY_B      = 8'hA2;

	// --------------------------------------------------------------------------
	// Field positions and reset values
	// --------------------------------------------------------------------------
	localparam int         DCPWM_RES_MSB       = 7;
	localparam int         DCPWM_RES_LSB       = 6;
	localparam int         DCPWM_PRESCALE_MSB  = 5;
	localparam int         DCPWM_PRESCALE_LSB  = 2;
	localparam int         DCPWM_EN_B_BIT      = 1;
	localparam int         DCPWM_EN_A_BIT      = 0;
	localparam logic [7:0] DCPWM_RESET_CTRL    = 8'h00;
	localparam logic [7:0] DCPWM_RESET_DUTY    = 8'h00;

	// Period lengths in prescaled counts for 5, 6, 7 and 8 bit resolution
	localparam logic [7:0] DCPWM_PERIOD_5B = 8'h1F;
	localparam logic [7:0] DCPWM_PERIOD_6B = 8'h3F;
	localparam logic [7:0] DCPWM_PERIOD_7B = 8'h7F;
	localparam logic [7:0] DCPWM_PERIOD_8B = 8'hFF;

	// Register access strobe carrier from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dcpwm_sfr_req_t;

	// Shared timing settings passed to each channel
	typedef struct packed {
		logic       tick;
		logic [7:0] count;
		logic [7:0] mask;
	} dcpwm_timebase_t;

endpackage

// [verilog/dcpwm_channel.sv]
// One output channel: compares the shared period count with its duty value
`timescale 1ns/10ps
`default_nettype none
module dcpwm_channel
	import dcpwm_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            reset_n,
	input  wire logic            clk_en,
	input  wire dcpwm_timebase_t timebase,
	input  wire logic [7:0]      duty,
	input  wire logic            enable,
	output logic                 pulse_q
);

	logic pulse_d;

	// Duty is taken live, so a write mid-period acts on the next compare
	always_comb begin
		pulse_d = enable && ((timebase.count & timebase.mask) < (duty & timebase.mask));
	end

	// Registered so the pin never sees a compare glitch
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pulse_q <= 1'b0;
		end else if (clk_en) begin
			pulse_q <= pulse_d;
		end
	end

endmodule
`default_nettype wire

// [verif/dcpwm_sva.sv]
// Checker of register and pin relations at the modulator top
`timescale 1ns/10ps
`default_nettype none
module dcpwm_sva
	import dcpwm_pkg::*;
(
	input wire logic           sys_clk,
	input wire logic           reset_n,
	input wire logic           clk_en,
	input wire dcpwm_sfr_req_t sfr_req,
	input wire logic [7:0]     sfr_rdata_q,
	input wire logic           sfr_hit_q,
	input wire logic           pulse_out_a,
	input wire logic           pulse_out_b
);
	logic mapped;
	logic rd;
	logic wc;
	logic wa;
	logic wb;
	// Decode kept here so each property stays short
	assign mapped = sfr_req.addr inside {DCPWM_ADDR_PERIOD_CTRL, DCPWM_ADDR_DUTY_A, DCPWM_ADDR_DUTY_B};
	assign rd = clk_en && sfr_req.rd;
	assign wc = clk_en && sfr_req.wr && sfr_req.addr == DCPWM_ADDR_PERIOD_CTRL;
	assign wa = clk_en && sfr_req.wr && sfr_req.addr == DCPWM_ADDR_DUTY_A;
	assign wb = clk_en && sfr_req.wr && sfr_req.addr == DCPWM_ADDR_DUTY_B;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Two quiet cycles cover the register load and the single pin flop
	sequence s_quiet; (clk_en && !sfr_req.wr) [*2]; endsequence
	sequence s_wr_rd; wb ##1 rd && sfr_req.addr == DCPWM_ADDR_DUTY_B; endsequence
	property p_hit; rd && mapped |=> sfr_hit_q; endproperty
	a_hit: assert property (p_hit) else $error("mapped read gave no hit");
	property p_unmap; rd && !mapped |=> !sfr_hit_q && sfr_rdata_q == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read answered");
	property p_idle; clk_en && !sfr_req.rd |=> !sfr_hit_q && sfr_rdata_q == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_wr_rd; s_wr_rd |=> sfr_rdata_q == $past(sfr_req.wdata, 2); endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("readback differs");
	property p_dis_a; wc && !sfr_req.wdata[0] ##1 s_quiet |=> !pulse_out_a; endproperty
	a_dis_a: assert property (p_dis_a) else $error("disabled pin a high");
	property p_dis_b; wc && !sfr_req.wdata[1] ##1 s_quiet |=> !pulse_out_b; endproperty
	a_dis_b: assert property (p_dis_b) else $error("disabled pin b high");
	property p_zero_a; wa && sfr_req.wdata == 8'h00 ##1 s_quiet |=> !pulse_out_a; endproperty
	a_zero_a: assert property (p_zero_a) else $error("zero duty pin a high");
	property p_zero_b; wb && sfr_req.wdata == 8'h00 ##1 s_quiet |=> !pulse_out_b; endproperty
	a_zero_b: assert property (p_zero_b) else $error("zero duty pin b high");
	property p_freeze_reg; !clk_en |=> $stable(sfr_rdata_q) && $stable(sfr_hit_q); endproperty
	a_freeze_reg: assert property (p_freeze_reg) else $error("register outputs moved while frozen");
	property p_freeze_pin; !clk_en |=> $stable(pulse_out_a) && $stable(pulse_out_b); endproperty
	a_freeze_pin: assert property (p_freeze_pin) else $error("pins moved while frozen");
endmodule
bind dcpwm_top dcpwm_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .sfr_req(sfr_req),
	.sfr_rdata_q(sfr_rdata_q), .sfr_hit_q(sfr_hit_q), .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b));
`default_nettype wire

// [verif/dcpwm_load.sv]
// Load model on the two pulse pins
`timescale 1ns/10ps
`default_nettype none
module dcpwm_load (
	input  wire logic       sys_clk,
	input  wire logic       clr,
	input  wire logic [1:0] pin,
	output logic [15:0]     hi_a,
	output logic [15:0]     hi_b
);
	// Loads only listen; high counts over whole periods judge the duty
	always_ff @(posedge sys_clk) begin
		hi_a <= clr ? 16'h0000 : hi_a + {15'h0000, pin[0]};
		hi_b <= clr ? 16'h0000 : hi_b + {15'h0000, pin[1]};
	end
endmodule
`default_nettype wire

// [verif/dual_channel_pwm_tb_top.sv]
// Self-checking bench for the dual-channel pulse-width modulator
`timescale 1ns/10ps
`default_nettype none
module dual_channel_pwm_tb_top
	import dcpwm_pkg::*;
;
	logic           sys_clk;
	logic           reset_n;
	logic           clk_en;
	logic           clr;
	logic           pulse_out_a;
	logic           pulse_out_b;
	logic           sfr_hit_q;
	logic [7:0]     sfr_rdata_q;
	logic [15:0]    hi_a;
	logic [15:0]    hi_b;
	dcpwm_sfr_req_t sfr_req;
	int             err_count;
	int             n_tests;
	dcpwm_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .sfr_req(sfr_req),
		.sfr_rdata_q(sfr_rdata_q), .sfr_hit_q(sfr_hit_q), .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b));
	dcpwm_load load (.sys_clk(sys_clk), .clr(clr), .pin({pulse_out_b, pulse_out_a}), .hi_a(hi_a), .hi_b(hi_b));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Request held across exactly one taking edge
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		sfr_req = '{wr: w, rd: r, addr: a, wdata: d};
		@(posedge sys_clk);
		#1;
	endtask
	task automatic idle(input int n);
		sfr_req = '0;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		op(1'b0, 1'b1, a, 8'h00);
		chk("rdata", {8'h00, exp}, {8'h00, sfr_rdata_q});
		chk("hit", {15'h0000, hit}, {15'h0000, sfr_hit_q});
	endtask
	task automatic t_regs();
		rd(DCPWM_ADDR_PERIOD_CTRL, 8'h00, 1'b1);
		rd(DCPWM_ADDR_DUTY_A, 8'h00, 1'b1);
		rd(DCPWM_ADDR_DUTY_B, 8'h00, 1'b1);
		op(1'b1, 1'b0, DCPWM_ADDR_DUTY_B, 8'h3C);
		rd(DCPWM_ADDR_DUTY_B, 8'h3C, 1'b1);
		op(1'b1, 1'b0, 8'hB3, 8'h55);
		rd(8'hB3, 8'h00, 1'b0);
	endtask
	// Each resolution with a growing prescale; upper duty bits must be ignored
	task automatic t_period();
		logic [7:0] m;
		int p;
		int len;
		for (int r = 0; r < 4; r++) begin
			p = r * 5;
			m = 8'hFF >> (3 - r);
			len = m * (p + 1);
			op(1'b1, 1'b0, DCPWM_ADDR_DUTY_A, 8'hE3);
			op(1'b1, 1'b0, DCPWM_ADDR_DUTY_B, 8'h5A);
			op(1'b1, 1'b0, DCPWM_ADDR_PERIOD_CTRL, {r[1:0], p[3:0], r[0], ~r[0]});
			idle(len + 4);
			clr = 1'b1;
			idle(1);
			clr = 1'b0;
			idle(2 * len);
			chk("high a", r[0] ? 16'h0000 : 16'(2 * (8'hE3 & m) * (p + 1)), hi_a);
			chk("high b", r[0] ? 16'(2 * (8'h5A & m) * (p + 1)) : 16'h0000, hi_b);
		end
	endtask
	// Duty changes in mid-period act without waiting for the period end
	task automatic t_live();
		op(1'b1, 1'b0, DCPWM_ADDR_DUTY_B, 8'hFF);
		idle(2);
		chk("pin b full", 16'h0001, {15'h0000, pulse_out_b});
		op(1'b1, 1'b0, DCPWM_ADDR_DUTY_B, 8'h00);
		idle(2);
		chk("pin b zero", 16'h0000, {15'h0000, pulse_out_b});
		op(1'b1, 1'b0, DCPWM_ADDR_DUTY_A, 8'h00);
		idle(3);
	endtask
	// A low clock enable must ignore strobes and hold the read data and hit flag
	task automatic t_freeze();
		op(1'b1, 1'b0, DCPWM_ADDR_DUTY_A, 8'h11);
		rd(DCPWM_ADDR_DUTY_A, 8'h11, 1'b1);
		clk_en = 1'b0;
		op(1'b1, 1'b0, DCPWM_ADDR_DUTY_A, 8'h22);
		op(1'b0, 1'b1, DCPWM_ADDR_PERIOD_CTRL, 8'h00);
		chk("frozen rdata", 16'h0011, {8'h00, sfr_rdata_q});
		chk("frozen hit", 16'h0001, {15'h0000, sfr_hit_q});
		clk_en = 1'b1;
		rd(DCPWM_ADDR_DUTY_A, 8'h11, 1'b1);
	endtask
	// Mid-run reset with both channels enabled clears pin a, the read data, and the control and duty A registers
	task automatic t_reset();
		op(1'b1, 1'b0, DCPWM_ADDR_PERIOD_CTRL, 8'h03);
		op(1'b1, 1'b0, DCPWM_ADDR_DUTY_A, 8'h1F);
		rd(DCPWM_ADDR_PERIOD_CTRL, 8'h03, 1'b1);
		idle(1);
		chk("pin a full", 16'h0001, {15'h0000, pulse_out_a});
		chk("pin b zero duty", 16'h0000, {15'h0000, pulse_out_b});
		reset_n = 1'b0;
		idle(2);
		chk("pin a in reset", 16'h0000, {15'h0000, pulse_out_a});
		chk("rdata in reset", 16'h0000, {8'h00, sfr_rdata_q});
		reset_n = 1'b1;
		rd(DCPWM_ADDR_PERIOD_CTRL, 8'h00, 1'b1);
		rd(DCPWM_ADDR_DUTY_A, 8'h00, 1'b1);
	endtask
	task automatic stop_test();
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		clr = 1'b0;
		sfr_req = '0;
		err_count = 0;
		n_tests = 0;
		repeat (8) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		t_regs();
		t_period();
		t_live();
		t_freeze();
		t_reset();
		stop_test();
	end
endmodule
`default_nettype wire
